// ---- verilog/txsfp_pkg.sv ----
// transmit status return and data fifo packing: shared constants
// assumes a 32-bit apb register bus and a single clock domain
package txsfp_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int            ADDR_W       = 8;
  localparam logic [7:0]    REG_CFG      = 8'h00;  // control bits
  localparam logic [7:0]    REG_DATA     = 8'h04;  // write-only data port
  localparam logic [7:0]    REG_STATUS   = 8'h08;  // read pops one status word
  localparam logic [7:0]    REG_INFO     = 8'h0C;  // fill levels
  localparam logic [7:0]    REG_ERR      = 8'h10;  // sticky error, write one to clear

  // control register fields and reset value
  localparam int            CFG_PERMIT   = 0;      // status_overrun_permit
  localparam int            CFG_DEFCHK   = 1;      // deferral checking enable
  localparam logic [1:0]    CFG_RESET    = 2'h0;
  localparam int            ERR_BIT      = 0;
  localparam int            INFO_DFREE   = 16;     // data fifo free words at [31:16]

  // ****************************************
  // first command word layout
  // ****************************************
  localparam int            CA_SIZE_LO   = 0;      // buffer size in bytes, 11 bits
  localparam int            CA_SIZE_W    = 11;
  localparam int            CA_LS        = 12;     // last_segment
  localparam int            CA_FS        = 13;     // first_segment
  localparam int            CA_OFF_LO    = 16;     // data start offset, 5 bits
  localparam int            CA_OFF_W     = 5;
  localparam int            CA_ALIGN_LO  = 24;     // end alignment 00:4 01:16 10:32 bytes
  // second command word
  localparam int            CB_CSUM      = 14;     // checksum_request
  localparam int            CB_TAG_LO    = 16;     // packet tag [31:16]

  // ****************************************
  // status word layout
  // ****************************************
  localparam int            ST_TAG_LO    = 16;
  localparam int            ST_ES        = 15;     // error_summary
  localparam int            ST_LOSSCAR   = 11;
  localparam int            ST_NOCAR     = 10;
  localparam int            ST_LATECOL   = 9;
  localparam int            ST_EXCOL     = 8;
  localparam int            ST_COLCNT_LO = 3;
  localparam int            ST_EXDEF     = 2;
  localparam int            ST_RSVD1     = 1;
  localparam int            ST_DEFER     = 0;

  // ****************************************
  // helpers
  // ****************************************
  // words kept for one buffer: sub-word offset plus payload, rounded up
  function automatic logic [9:0] txsfp_kept_words(input logic [31:0] cmdA);
    logic [11:0] bytes;
    bytes = {10'h000, cmdA[CA_OFF_LO +: 2]} + {1'b0, cmdA[CA_SIZE_LO +: CA_SIZE_W]} + 12'h003;
    return bytes[11:2];
  endfunction

endpackage : txsfp_pkg

// ---- verilog/txsfp_core.sv ----
// transmit status return and data fifo packing for the host mac path
// assumes an apb3 master on one side and a mac that drains words and reports one result per packet
`timescale 1ns/10ps
`default_nettype none

module txsfp_core #(
  parameter int DATA_DEPTH = 512,   // data fifo words
  parameter int STAT_DEPTH = 16     // status fifo words
) (
  // clock and reset
  input  wire  logic                         clk,
  input  wire  logic                         rst_b,
  // apb slave
  input  wire  logic                         psel,
  input  wire  logic                         penable,
  input  wire  logic                         pwrite,
  input  wire  logic [txsfp_pkg::ADDR_W-1:0] paddr,
  input  wire  logic [31:0]                  pwdata,
  output logic       [31:0]                  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // word stream toward the mac
  output logic       [31:0]                  macData,
  output logic                               macValid,
  output logic                               macLast,
  input  wire  logic                         macReady,
  // per-packet result from the mac
  input  wire  logic                         txDoneIn,
  input  wire  logic                         lossCarrierIn,
  input  wire  logic                         noCarrierIn,
  input  wire  logic                         lateCollisionIn,
  input  wire  logic                         excessCollisionIn,
  input  wire  logic [3:0]                   collisionCountIn,
  input  wire  logic                         excessDeferralIn,
  input  wire  logic                         deferredIn,
  // status
  output logic                               transmitterErrorFlag,
  output logic [$clog2(STAT_DEPTH):0]        statusFifoFillCount
);
  import txsfp_pkg::*;

  localparam int DPW = $clog2(DATA_DEPTH);
  localparam int SPW = $clog2(STAT_DEPTH);

  typedef enum logic [1:0] {PK_A, PK_B, PK_DATA} txsfp_pack_t;
  typedef enum logic [1:0] {DR_A, DR_B, DR_DATA, DR_WAIT} txsfp_drain_t;

  // ****************************************
  // apb decode
  // ****************************************
  logic          setup;
  logic          access;
  logic          wrData;
  logic          rdStatus;
  logic [1:0]    cfg_r;
  logic          err_r;
  logic          errSet;

  assign setup    = psel & ~penable;
  assign access   = psel & penable;  // pready is high from the first edge after reset, so every access completes
  assign wrData   = access & pwrite & (paddr == REG_DATA);
  assign rdStatus = access & ~pwrite & (paddr == REG_STATUS);

  // control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= CFG_RESET;
    end else if (access && pwrite && paddr == REG_CFG) begin
      cfg_r <= pwdata[1:0];
    end
  end

  // sticky error: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else if (errSet) begin
      err_r <= 1'b1;
    end else if (access && pwrite && paddr == REG_ERR && pwdata[ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end
  assign transmitterErrorFlag = err_r;

  // ****************************************
  // data fifo storage
  // ****************************************
  logic [31:0]   dMem [DATA_DEPTH];
  logic [DPW-1:0] dWp_r;
  logic [DPW-1:0] dRp_r;
  logic [DPW:0]   dCount_r;
  logic          dPush;
  logic          dPushReq;
  logic          dPop;
  logic          dFull;
  logic          dEmpty;
  logic [31:0]   dHead;

  assign dFull  = (dCount_r == (DPW+1)'(DATA_DEPTH));
  assign dEmpty = (dCount_r == '0);
  assign dPush  = dPushReq & ~dFull;
  assign dHead  = dMem[dRp_r];

  // memory write, no reset needed on the array
  always_ff @(posedge clk) begin
    if (dPush) begin
      dMem[dWp_r] <= pwdata;
    end
  end

  // pointers and level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dWp_r    <= '0;
      dRp_r    <= '0;
      dCount_r <= '0;
    end else begin
      if (dPush) begin
        dWp_r <= (dWp_r == DPW'(DATA_DEPTH-1)) ? '0 : dWp_r + 1'b1;
      end
      if (dPop) begin
        dRp_r <= (dRp_r == DPW'(DATA_DEPTH-1)) ? '0 : dRp_r + 1'b1;
      end
      dCount_r <= dCount_r + (DPW+1)'(dPush) - (DPW+1)'(dPop);
    end
  end

  // ****************************************
  // packer: host writes to data fifo
  // ****************************************
  txsfp_pack_t   pkState_r;
  logic [31:0]   cmdA_r;
  logic [31:0]   cmdBRef_r;
  logic [9:0]    wordIdx_r;
  logic [9:0]    hostWords_r;
  logic [9:0]    keepLo_r;
  logic [9:0]    keepHi_r;
  logic [12:0]   total;
  logic [12:0]   alignMask;
  logic [12:0]   rounded;
  logic          keepWord;

  // host words per buffer: offset plus size rounded up to the end alignment
  always_comb begin
    total = {8'h00, pwdata[CA_OFF_LO +: CA_OFF_W]} + {2'b00, pwdata[CA_SIZE_LO +: CA_SIZE_W]};
    case (pwdata[CA_ALIGN_LO +: 2])
      2'h1:    alignMask = 13'h000F;
      2'h2:    alignMask = 13'h001F;
      default: alignMask = 13'h0003;
    endcase
    rounded = (total + alignMask) & ~alignMask;
  end

  // inside a buffer, only words between the stripped offset and padding go in
  assign keepWord = (wordIdx_r >= keepLo_r) && (wordIdx_r < keepHi_r);

  always_comb begin
    dPushReq = 1'b0;
    if (wrData) begin
      case (pkState_r)
        PK_A:    dPushReq = 1'b1;
        PK_B:    dPushReq = cmdA_r[CA_FS];
        PK_DATA: dPushReq = keepWord;
        default: dPushReq = 1'b0;
      endcase
    end
  end

  // host overrun or second command mismatch raise the error flag
  assign errSet = (dPushReq & dFull)
                | (wrData & (pkState_r == PK_B) & ~cmdA_r[CA_FS] & (pwdata != cmdBRef_r));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pkState_r   <= PK_A;
      cmdA_r      <= '0;
      cmdBRef_r   <= '0;
      wordIdx_r   <= '0;
      hostWords_r <= '0;
      keepLo_r    <= '0;
      keepHi_r    <= '0;
    end else if (wrData) begin
      case (pkState_r)
        PK_A: begin
          cmdA_r      <= pwdata;
          hostWords_r <= rounded[11:2];
          keepLo_r    <= {7'h00, pwdata[CA_OFF_LO+2 +: 3]};
          keepHi_r    <= {7'h00, pwdata[CA_OFF_LO+2 +: 3]} + txsfp_kept_words(pwdata);
          pkState_r   <= PK_B;
        end
        PK_B: begin
          if (cmdA_r[CA_FS]) begin
            cmdBRef_r <= pwdata;
          end
          wordIdx_r <= '0;
          pkState_r <= (hostWords_r == '0) ? PK_A : PK_DATA;
        end
        PK_DATA: begin
          wordIdx_r <= wordIdx_r + 10'h001;
          if (wordIdx_r + 10'h001 == hostWords_r) begin
            pkState_r <= PK_A;
          end
        end
        default: pkState_r <= PK_A;
      endcase
    end
  end

  // ****************************************
  // drain: data fifo toward the mac
  // ****************************************
  txsfp_drain_t  drState_r;
  logic [9:0]    dLeft_r;
  logic          lastSeg_r;
  logic [15:0]   tag_r;
  logic          outFree;
  logic          statFull;
  logic          suspend;
  logic [9:0]    headKept;

  assign outFree  = ~macValid | macReady;
  // with status_overrun_permit clear, a packet only starts with room for its status; once started it always fits
  assign suspend  = ~cfg_r[CFG_PERMIT] & statFull;
  assign headKept = txsfp_kept_words(dHead);

  always_comb begin
    dPop = 1'b0;
    if (!dEmpty) begin
      case (drState_r)
        DR_A:    dPop = ~(dHead[CA_FS] & suspend);
        DR_B:    dPop = 1'b1;
        DR_DATA: dPop = outFree;
        default: dPop = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drState_r <= DR_A;
      dLeft_r   <= '0;
      lastSeg_r <= 1'b0;
      tag_r     <= '0;
    end else begin
      case (drState_r)
        DR_A: begin
          if (dPop) begin
            dLeft_r   <= headKept;
            lastSeg_r <= dHead[CA_LS];
            if (dHead[CA_FS]) begin
              drState_r <= DR_B;
            end else if (headKept == '0) begin
              drState_r <= dHead[CA_LS] ? DR_WAIT : DR_A;
            end else begin
              drState_r <= DR_DATA;
            end
          end
        end
        DR_B: begin
          if (dPop) begin
            tag_r <= dHead[CB_TAG_LO +: 16];
            if (dLeft_r == '0) begin
              drState_r <= lastSeg_r ? DR_WAIT : DR_A;
            end else begin
              drState_r <= DR_DATA;
            end
          end
        end
        DR_DATA: begin
          if (dPop) begin
            dLeft_r <= dLeft_r - 10'h001;
            if (dLeft_r == 10'h001) begin
              drState_r <= lastSeg_r ? DR_WAIT : DR_A;
            end
          end
        end
        DR_WAIT: begin
          if (txDoneIn) begin
            drState_r <= DR_A;
          end
        end
        default: drState_r <= DR_A;
      endcase
    end
  end

  // output register toward the mac
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      macData  <= '0;
      macValid <= 1'b0;
      macLast  <= 1'b0;
    end else if (drState_r == DR_DATA && dPop) begin
      macData  <= dHead;
      macValid <= 1'b1;
      macLast  <= lastSeg_r & (dLeft_r == 10'h001);
    end else if (macReady) begin
      macValid <= 1'b0;
      macLast  <= 1'b0;
    end
  end

  // ****************************************
  // status fifo
  // ****************************************
  logic [31:0]    sMem [STAT_DEPTH];
  logic [SPW-1:0] sWp_r;
  logic [SPW-1:0] sRp_r;
  logic [SPW:0]   sCount_r;
  logic           sDone;
  logic           sPush;
  logic           sPop;
  logic [31:0]    statWord;
  logic           exDefer;
  logic           statArm_r;

  assign statFull = (sCount_r == (SPW+1)'(STAT_DEPTH));
  assign sDone    = txDoneIn & (drState_r == DR_WAIT);
  assign sPush    = sDone & ~statFull;
  assign sPop     = rdStatus & statArm_r;
  assign exDefer  = excessDeferralIn & cfg_r[CFG_DEFCHK];

  // pop only a word the setup cycle really returned: a push landing
  // between setup and access must not be popped unseen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statArm_r <= 1'b0;
    end else if (setup) begin
      statArm_r <= ~pwrite & (paddr == REG_STATUS) & (sCount_r != '0);
    end
  end

  // status word assembly, reserved bits forced low
  always_comb begin
    statWord                         = '0;
    statWord[ST_TAG_LO +: 16]        = tag_r;
    statWord[ST_LOSSCAR]             = lossCarrierIn;
    statWord[ST_NOCAR]               = noCarrierIn;
    statWord[ST_LATECOL]             = lateCollisionIn;
    statWord[ST_EXCOL]               = excessCollisionIn;
    statWord[ST_COLCNT_LO +: 4]      = collisionCountIn;
    statWord[ST_EXDEF]               = exDefer;
    statWord[ST_DEFER]               = deferredIn;
    statWord[ST_ES]                  = lossCarrierIn | noCarrierIn | lateCollisionIn
                                     | excessCollisionIn | exDefer | statWord[ST_RSVD1];
  end

  always_ff @(posedge clk) begin
    if (sPush) begin
      sMem[sWp_r] <= statWord;
    end
  end

  // count holds at the top when a word is dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sWp_r    <= '0;
      sRp_r    <= '0;
      sCount_r <= '0;
    end else begin
      if (sPush) begin
        sWp_r <= (sWp_r == SPW'(STAT_DEPTH-1)) ? '0 : sWp_r + 1'b1;
      end
      if (sPop) begin
        sRp_r <= (sRp_r == SPW'(STAT_DEPTH-1)) ? '0 : sRp_r + 1'b1;
      end
      sCount_r <= sCount_r + (SPW+1)'(sPush) - (SPW+1)'(sPop);
    end
  end
  assign statusFifoFillCount = sCount_r;

  // ****************************************
  // apb read data, answered with no wait state
  // ****************************************
  logic [15:0] dFree;
  assign dFree = 16'(DATA_DEPTH) - 16'(dCount_r);

  // read data is captured in the setup cycle so the access phase sees a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= '0;
        pslverr <= 1'b0;
        case (paddr)
          REG_CFG:    prdata <= {30'h0, cfg_r};
          REG_DATA:   pslverr <= ~pwrite;
          REG_STATUS: begin
            prdata  <= (sCount_r != '0) ? sMem[sRp_r] : '0;
            pslverr <= pwrite;
          end
          REG_INFO:   prdata <= {dFree, 16'(sCount_r)};
          REG_ERR:    prdata <= {31'h0, err_r};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // txsfp_core

`default_nettype wire

// ---- verification/txsfp_props.sv ----
// checker for the status fifo, apb answers and mac stream of txsfp_core
// assumes it is bound into txsfp_core and sees only its ports
`timescale 1ns/10ps
`default_nettype none
// ****************
// checker
// ****************
module txsfp_props #(
  parameter int STAT_DEPTH = 16
) (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          rst_b,
  // apb
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [txsfp_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // mac side
  input wire logic [31:0]                   macData,
  input wire logic                          macValid,
  input wire logic                          macLast,
  input wire logic                          macReady,
  input wire logic                          txDoneIn,
  input wire logic [$clog2(STAT_DEPTH):0]   statusFifoFillCount
);
  import txsfp_pkg::*;
  logic statRd;
  // completed read of the status port, which pops one entry
  assign statRd = psel && penable && !pwrite && paddr == REG_STATUS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ready_after_reset_a: assert property ($past(rst_b) |-> pready) else $error("pready low after reset");
  fill_bound_a: assert property (statusFifoFillCount <= STAT_DEPTH)
    else $error("status fill count above depth");
  push_cause_a: assert property (statusFifoFillCount > $past(statusFifoFillCount) |->
    $past(txDoneIn) && statusFifoFillCount == $past(statusFifoFillCount) + 1'b1) else $error("status push bad");
  full_hold_a: assert property (statusFifoFillCount == STAT_DEPTH && !statRd |=>
    statusFifoFillCount == STAT_DEPTH) else $error("full count did not hold");
  pop_step_a: assert property (statRd && $past(statusFifoFillCount) != 0 && !txDoneIn |=>
    statusFifoFillCount == $past(statusFifoFillCount) - 1'b1) else $error("status read did not pop");
  rsvd_zero_a: assert property (statRd |-> prdata[14:12] == 3'h0 && !prdata[7] && !prdata[1])
    else $error("reserved status bit set");
  error_summary_a: assert property (statRd |-> prdata[15] == (|prdata[11:8] || prdata[2] || prdata[1]))
    else $error("summary bit wrong");
  bad_addr_a: assert property (psel && penable && paddr > REG_ERR |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  stream_hold_a: assert property (macValid && !macReady |=>
    macValid && $stable(macData) && $stable(macLast)) else $error("stream word dropped before accept");
  last_gap_a: assert property (macValid && macReady && macLast |=> !macValid)
    else $error("word sent before packet result");

  cover property (statRd && statusFifoFillCount != 0);
  cover property (statusFifoFillCount == STAT_DEPTH && txDoneIn);
  cover property (macValid && macReady && macLast);
endmodule // txsfp_props

bind txsfp_core txsfp_props #(.STAT_DEPTH(STAT_DEPTH)) u_txsfp_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .macData(macData), .macValid(macValid),
  .macLast(macLast), .macReady(macReady), .txDoneIn(txDoneIn), .statusFifoFillCount(statusFifoFillCount)
);
`default_nettype wire

// ---- verification/txsfp_mac_model.sv ----
// mac model on the far side of the word stream
// assumes the bench sets stall and the result of the next packet
`timescale 1ns/10ps
`default_nettype none
// ****************
// mac model
// ****************
module txsfp_mac_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // stream from the block
  input  wire logic       macValid,
  input  wire logic       macLast,
  output logic            macReady,
  // bench controls
  input  wire logic       stall,
  input  wire logic [9:0] result,
  // packet result toward the block
  output logic            txDoneIn,
  output logic [9:0]      resultOut
);
  logic       waiting_r;
  logic [1:0] delay_r;
  // take words, then report the attempt a few cycles after the last one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      macReady  <= 1'b0;
      txDoneIn  <= 1'b0;
      waiting_r <= 1'b0;
      delay_r   <= 2'h0;
    end else begin
      txDoneIn <= 1'b0;
      if (waiting_r) begin
        delay_r <= delay_r + 2'h1;
        if (delay_r == 2'h3) begin
          txDoneIn  <= 1'b1;
          waiting_r <= 1'b0;
        end
      end else if (macValid && macReady && macLast) begin
        waiting_r <= 1'b1;
        macReady  <= 1'b0;
      end else begin
        macReady <= stall ? !macReady : 1'b1;  // stalling toggles ready
      end
    end
  end
  // result lines only count in the done cycle, so scramble them elsewhere
  assign resultOut = txDoneIn ? result : ~result;
endmodule // txsfp_mac_model
`default_nettype wire

// ---- verification/txsfp_core_test.sv ----
// self-checking bench for txsfp_core: apb host tasks and a mac model
// assumes the checker is bound in and the status fifo is two deep
`timescale 1ns/10ps
`default_nettype none
// ****************
// bench
// ****************
module txsfp_core_test;
  import txsfp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, macData, rdq;
  logic        pready, pslverr, macValid, macLast, macReady, txDoneIn, transmitterErrorFlag, rde;
  logic [1:0]  statusFifoFillCount;
  logic [9:0]  resOut;
  logic [9:0]  result = 10'h000;
  logic        stall = 1'b0;
  logic [31:0] got[$];
  logic        lastQ[$];
  int          n_errors = 0;
  int          checked = 0;

  always #10 clk = ~clk;

  txsfp_core #(.STAT_DEPTH(2)) u_txsfp_core (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .macData(macData),
    .macValid(macValid), .macLast(macLast), .macReady(macReady), .txDoneIn(txDoneIn),
    .lossCarrierIn(resOut[9]), .noCarrierIn(resOut[8]), .lateCollisionIn(resOut[7]),
    .excessCollisionIn(resOut[6]), .collisionCountIn(resOut[5:2]), .excessDeferralIn(resOut[1]),
    .deferredIn(resOut[0]), .transmitterErrorFlag(transmitterErrorFlag),
    .statusFifoFillCount(statusFifoFillCount));
  txsfp_mac_model u_txsfp_mac_model (
    .clk(clk), .rst_b(rst_b), .macValid(macValid), .macLast(macLast), .macReady(macReady),
    .stall(stall), .result(result), .txDoneIn(txDoneIn), .resultOut(resOut));

  // record every word the mac accepts
  always @(posedge clk) begin
    if (macValid === 1'b1 && macReady === 1'b1) begin
      got.push_back(macData);
      lastQ.push_back(macLast);
    end
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  // one apb transfer; answer taken at the edge that samples pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      finish_test();
    end
    rdq = prdata;
    rde = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // bounded wait for the mac result pulse, then one edge for the push
  task automatic wdone();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (txDoneIn !== 1'b1 && i < 200);
    if (txDoneIn !== 1'b1) begin
      chk("txDoneIn", 32'h1, 32'h0);
      finish_test();
    end
    @(posedge clk);
  endtask
  // single buffer packet: both segment flags, four bytes
  task automatic pkt(input logic [15:0] tag, input logic [31:0] d);
    wr(REG_DATA, 32'h0000_3004);
    wr(REG_DATA, {tag, 16'h0000});
    wr(REG_DATA, d);
  endtask
  // result bits: loss, none, late, excess, count[3:0], deferral, deferred
  function automatic logic [31:0] stexp(input logic [15:0] tag, input logic [9:0] r, input logic dc);
    logic ed;
    ed = r[1] & dc;
    return {tag, |{r[9:6], ed}, 3'h0, r[9:6], 1'b0, r[5:2], ed, 1'b0, r[0]};
  endfunction

  task automatic t_status();
    wr(REG_CFG, 32'h2);
    result <= 10'h217;  // loss of carrier, five collisions, deferral
    pkt(16'hA5C3, 32'h1234_5678);
    wdone();
    chk("stream word", 32'h1234_5678, got[got.size()-1]);
    chk("stream last", 32'h1, 32'(lastQ[lastQ.size()-1]));
    rd(REG_STATUS);
    chk("status", stexp(16'hA5C3, 10'h217, 1'b1), rdq);
    wr(REG_CFG, 32'h0);
    result <= 10'h1E2;  // deferral flag must be masked now
    pkt(16'h0F0F, 32'hCAFE_0001);
    wdone();
    rd(REG_STATUS);
    chk("status masked", stexp(16'h0F0F, 10'h1E2, 1'b0), rdq);
    $display("t_status done");
  endtask
  task automatic t_offset();
    int n;
    n = got.size();
    stall  <= 1'b1;
    result <= 10'h000;
    wr(REG_DATA, 32'h0106_3003);  // offset six, 16 byte end, three bytes
    wr(REG_DATA, 32'h7777_0000);
    for (int k = 0; k < 4; k++) begin
      wr(REG_DATA, 32'hD000_0000 + k);
    end
    wdone();
    stall <= 1'b0;
    chk("kept words", n + 2, got.size());
    chk("first kept", 32'hD000_0001, got[n]);
    chk("second kept", 32'hD000_0002, got[n+1]);
    chk("kept last", 32'h1, 32'(lastQ[n+1]));
    rd(REG_STATUS);
    chk("offset tag", stexp(16'h7777, 10'h000, 1'b0), rdq);
    $display("t_offset done");
  endtask
  task automatic t_suspend();
    int n;
    pkt(16'h0001, 32'h11);
    wdone();
    pkt(16'h0002, 32'h22);
    wdone();
    chk("fill full", 32'h2, 32'(statusFifoFillCount));
    n = got.size();
    pkt(16'h0003, 32'h33);
    repeat (20) @(posedge clk);
    chk("suspended", n, got.size());
    rd(REG_STATUS);
    chk("tag one", stexp(16'h0001, 10'h000, 1'b0), rdq);
    wdone();
    chk("resumed", n + 1, got.size());
    rd(REG_STATUS);
    chk("tag two", stexp(16'h0002, 10'h000, 1'b0), rdq);
    rd(REG_STATUS);
    chk("tag three", stexp(16'h0003, 10'h000, 1'b0), rdq);
    $display("t_suspend done");
  endtask
  task automatic t_permit();
    wr(REG_CFG, 32'h1);
    for (int k = 1; k <= 3; k++) begin
      pkt(16'(16'hA0 + k), 32'h0);
      wdone();
    end
    chk("fill held", 32'h2, 32'(statusFifoFillCount));
    rd(REG_STATUS);
    chk("kept first", stexp(16'h00A1, 10'h000, 1'b0), rdq);
    rd(REG_STATUS);
    chk("kept second", stexp(16'h00A2, 10'h000, 1'b0), rdq);
    rd(REG_STATUS);
    chk("dropped third", 32'h0, rdq);  // third status was dropped while full, so the empty fifo reads zero
    rd(REG_INFO);
    chk("fill levels", 32'h0200_0000, rdq);
    $display("t_permit done");
  endtask
  task automatic t_segments();
    wr(REG_CFG, 32'h0);
    wr(REG_DATA, 32'h0000_2004);  // first segment only
    wr(REG_DATA, 32'h0055_0000);
    wr(REG_DATA, 32'hB000_0001);
    wr(REG_DATA, 32'h0000_1004);  // last segment, other second word
    wr(REG_DATA, 32'h0066_0000);
    wr(REG_DATA, 32'hB000_0002);
    wdone();
    chk("error flag", 32'h1, 32'(transmitterErrorFlag));
    chk("segment data", 32'hB000_0002, got[got.size()-1]);
    rd(REG_STATUS);
    chk("segment tag", stexp(16'h0055, 10'h000, 1'b0), rdq);
    wr(REG_ERR, 32'h1);
    @(posedge clk);
    chk("error cleared", 32'h0, 32'(transmitterErrorFlag));
    rd(8'h40);
    chk("unmapped err", 32'h1, 32'(rde));
    chk("unmapped data", 32'h0, rdq);
    $display("t_segments done");
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    chk("pready in reset", 32'h0, 32'(pready));
    rst_b <= 1'b1;
    @(posedge clk);
    t_status();
    t_offset();
    t_suspend();
    t_permit();
    t_segments();
    finish_test();
  end
endmodule // txsfp_core_test
`default_nettype wire
